// ==== src/tcr_pkg.sv ====
// constants shared by the time capture and reference select block
// assumes one 250 MHz clock; host accesses arrive as single-cycle strobes
// Overview of operation
// - four capture sets, each two 32-bit words: major and minor time
// - any host access of the demand request register latches time into set 0
// - set 0 holds its value until the next demand request access
// - captured time is readable right after the request access, no waiting
// - any access of first request register latches time into set 1
// - set 1 can also latch on event input or periodic output edge
// - sets 2 and 3 latch only from their event inputs, never by access
// - event 2 shares level-shift code pin, event 3 shares external pps pin
// - mode codes: 0 code, 1 free run, 2 ext pps, 3 rtc, 6 satellite
// - outside free running and rtc, oscillator is steered to reference phase and frequency
// - once synchronized, time keeps counting in holdover when reference vanishes
// - code and satellite give major time; free run and ext pps need host load
// - ext pps tracked without time-of-day sync when pin 14 is not set as event 3; status valid only after earlier time-of-day sync
// - rtc mode takes major time from the rtc, no input reference
// - code mode accepts modulated or level-shift form of the time code
// - satellite gives major and minor; lock needs four, or one with position
// - edge-sense setting picks active edge of event 1 and periodic output
package tcr_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam logic [31:0] NS_PER_SEC = 32'h3B9ACA00;
    localparam logic [31:0] HALF_SEC_NS = 32'h1DCD6500;
    localparam logic [31:0] MINOR_STEP = 32'(CLK_PERIOD_NS);
    // reference loss timeout, in ms, and the derived cycle count
    localparam int REF_TIMEOUT_MS = 1500;
    localparam int REF_TIMEOUT_CYC = REF_TIMEOUT_MS * (1000000 / CLK_PERIOD_NS);
    // lock window on phase error, in ns
    localparam int LOCK_WINDOW_NS = 100;
    localparam logic [31:0] LOCK_WINDOW = 32'(LOCK_WINDOW_NS);
    localparam int TUNE_SHIFT = 4;
    // mode codes
    localparam logic [2:0] MODE_TIMECODE = 3'h0;
    localparam logic [2:0] MODE_FREERUN = 3'h1;
    localparam logic [2:0] MODE_EXT_PPS = 3'h2;
    localparam logic [2:0] MODE_RTC = 3'h3;
    localparam logic [2:0] MODE_SATELLITE = 3'h6;
    // satellite lock needs
    localparam logic [3:0] SAT_NEED_BLIND = 4'h4;
    localparam logic [3:0] SAT_NEED_KNOWN = 4'h1;
    // host register indices
    localparam logic [3:0] ADDR_DEMAND_REQ = 4'h0;
    localparam logic [3:0] ADDR_FIRST_REQ = 4'h1;
    localparam logic [3:0] ADDR_WORD_BASE = 4'h2;
    localparam logic [3:0] ADDR_WORD_LAST = 4'h9;
    localparam logic [3:0] ADDR_STATUS = 4'hA;
    // status word bit positions
    localparam int ST_LOCKED = 0;
    localparam int ST_TRACKING = 1;
    localparam int ST_HOLDOVER = 2;
    localparam int ST_TOD_SYNCED = 3;
    localparam int ST_MODE_LSB = 4;
    localparam int NUM_SETS = 4;
    localparam logic [1:0] SET_DEMAND = 2'h0;
    localparam logic [1:0] SET_FIRST = 2'h1;
    localparam logic [1:0] SET_SECOND = 2'h2;
    localparam logic [1:0] SET_THIRD = 2'h3;
    typedef enum logic [1:0] {SYNC_FREE, SYNC_ACQUIRE, SYNC_TRACK, SYNC_HOLD} tcr_sync_e;
endpackage

// ==== src/tcr_capture_mem.sv ====
// capture store: four sets of two words, one write port per set
// assumes the caller presents both words of a set in the same cycle
`timescale 1ns/100ps
module tcr_capture_mem import tcr_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // per-set capture strobes and the shared time count
    input wire logic [NUM_SETS-1:0] wr_en,
    input wire logic [31:0] wr_major,
    input wire logic [31:0] wr_minor,
    // registered read port
    input wire logic [2:0] rd_word,
    output logic [31:0] rd_data
);
    logic [31:0] major_q [NUM_SETS];
    logic [31:0] minor_q [NUM_SETS];
    logic [31:0] rd_data_q;
    logic [31:0] rd_data_d;

    // one writer per set so coincident events in different sets never collide
    for (genvar s = 0; s < NUM_SETS; s++) begin : g_set
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                major_q[s] <= 32'h00000000;
                minor_q[s] <= 32'h00000000;
            end else if (wr_en[s]) begin
                major_q[s] <= wr_major;
                minor_q[s] <= wr_minor;
            end
        end
    end

    // word a is major, word b is minor
    always_comb begin
        rd_data_d = rd_word[0] ? minor_q[rd_word[2:1]] : major_q[rd_word[2:1]];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= 32'h00000000;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data = rd_data_q;
endmodule

// ==== src/tcr_time_capture.sv ====
// time keeping, reference discipline and four time capture sets
// assumes all inputs synchronous to clk; mode and major load come from the mailbox
`timescale 1ns/100ps
module tcr_time_capture import tcr_pkg::*; #(
    parameter int REF_TIMEOUT = REF_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host register access
    input wire logic host_access,
    input wire logic host_write,
    input wire logic [3:0] host_addr,
    output logic [31:0] host_rdata,
    output logic host_rvalid,
    // mailbox results
    input wire logic [2:0] timing_mode,
    input wire logic major_load,
    input wire logic [31:0] major_load_value,
    // capture configuration
    input wire logic capture_edge_sense,
    input wire logic first_capture_periodic,
    input wire logic pin10_event_sel,
    input wire logic pin14_event_sel,
    // event and shared pins
    input wire logic first_event_time_word_b_in,
    input wire logic programmable_periodic_output,
    input wire logic pin10_in,
    input wire logic pin14_in,
    // time code decoders
    input wire logic tcode_form_am,
    input wire logic tcode_am_mark,
    input wire logic [31:0] tcode_am_major,
    input wire logic [31:0] tcode_ls_major,
    // satellite receiver and rtc
    input wire logic sat_pps,
    input wire logic [31:0] sat_major,
    input wire logic [3:0] sat_count,
    input wire logic sat_position_known,
    input wire logic [31:0] rtc_major,
    // oscillator steering and status
    output logic [31:0] osc_tune,
    output logic local_pps,
    output logic ref_locked,
    output logic ref_tracking,
    output logic holdover
);
    // input history for edge detection
    logic ev1_q, ppo_q, p10_q, p14_q;
    logic ev1_d, ppo_d, p10_d, p14_d;
    // time count
    logic [31:0] major_q, major_d, minor_q, minor_d;
    // discipline state
    tcr_sync_e sync_q, sync_d;
    logic [31:0] phase_q, phase_d, tune_q, tune_d;
    logic [31:0] ref_timer_q, ref_timer_d;
    logic tod_synced_q, tod_synced_d;
    logic locked_q, locked_d, pps_q, pps_d, hold_q, track_q;
    // host read path
    logic [31:0] rdata_q, rdata_d;
    logic rd_stage_q, rd_stage_d, rvalid_q, rvalid_d;
    logic status_sel_q, status_sel_d;
    logic word_sel_q, word_sel_d;
    // combinational helpers
    logic [NUM_SETS-1:0] cap_en;
    logic [2:0] mem_word;
    logic [31:0] mem_rdata;
    logic ev1_edge, ppo_edge, ev2_edge, ev3_edge;
    logic ref_edge, ref_gives_major, lock_allowed;
    logic [31:0] ref_major, minor_next, phase_now, freq_err, phase_abs, status_word;

    // edge detect following the edge-sense setting
    function automatic logic sel_edge(input logic now, input logic last, input logic rise);
        sel_edge = rise ? (now && !last) : (!now && last);
    endfunction

    always_comb begin
        ev1_d = first_event_time_word_b_in;
        ppo_d = programmable_periodic_output;
        p10_d = pin10_in;
        p14_d = pin14_in;
        ev1_edge = sel_edge(first_event_time_word_b_in, ev1_q, capture_edge_sense);
        ppo_edge = sel_edge(programmable_periodic_output, ppo_q, capture_edge_sense);
        // shared pins feed the event only when their event function is chosen
        ev2_edge = pin10_event_sel && sel_edge(pin10_in, p10_q, capture_edge_sense);
        ev3_edge = pin14_event_sel && sel_edge(pin14_in, p14_q, capture_edge_sense);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ev1_q <= 1'b0;
            ppo_q <= 1'b0;
            p10_q <= 1'b0;
            p14_q <= 1'b0;
        end else begin
            ev1_q <= ev1_d;
            ppo_q <= ppo_d;
            p10_q <= p10_d;
            p14_q <= p14_d;
        end
    end

    // capture strobes: access of a request register, or an event edge
    always_comb begin
        cap_en[SET_DEMAND] = host_access && host_addr == ADDR_DEMAND_REQ;
        cap_en[SET_FIRST] = (host_access && host_addr == ADDR_FIRST_REQ)
            || (first_capture_periodic ? ppo_edge : ev1_edge);
        cap_en[SET_SECOND] = ev2_edge;
        cap_en[SET_THIRD] = ev3_edge;
    end

    // reference selection per mode
    always_comb begin
        ref_edge = 1'b0;
        ref_major = major_q;
        ref_gives_major = 1'b0;
        lock_allowed = 1'b1;
        case (timing_mode)
            MODE_TIMECODE: begin
                // level-shift mark is the pin 10 rising edge when the pin carries code
                if (tcode_form_am) begin
                    ref_edge = tcode_am_mark;
                    ref_major = tcode_am_major;
                end else begin
                    ref_edge = !pin10_event_sel && pin10_in && !p10_q;
                    ref_major = tcode_ls_major;
                end
                ref_gives_major = 1'b1;
            end
            MODE_EXT_PPS: begin
                ref_edge = !pin14_event_sel && pin14_in && !p14_q;
                lock_allowed = tod_synced_q;
            end
            MODE_SATELLITE: begin
                // pps only counts once enough satellites are seen
                ref_edge = sat_pps && (sat_count >= SAT_NEED_BLIND
                    || (sat_position_known && sat_count >= SAT_NEED_KNOWN));
                ref_major = sat_major;
                ref_gives_major = 1'b1;
            end
            default: begin
                ref_edge = 1'b0; // free run and rtc have no input reference
            end
        endcase
    end

    // phase error: minor time at reference edge, folded to a signed half second
    always_comb begin
        phase_now = (minor_q >= HALF_SEC_NS) ? minor_q - NS_PER_SEC : minor_q;
        freq_err = phase_now - phase_q;
        phase_abs = phase_now[31] ? 32'h00000000 - phase_now : phase_now;
        minor_next = minor_q + MINOR_STEP;
    end

    // time count, discipline and holdover
    always_comb begin
        major_d = major_q;
        minor_d = minor_next;
        pps_d = 1'b0;
        sync_d = sync_q;
        phase_d = phase_q;
        tune_d = tune_q;
        tod_synced_d = tod_synced_q;
        locked_d = locked_q;
        ref_timer_d = ref_timer_q;
        // the count runs in every state, which is what keeps holdover time
        if (minor_next >= NS_PER_SEC) begin
            minor_d = 32'h00000000;
            major_d = (timing_mode == MODE_RTC) ? rtc_major : major_q + 32'h00000001;
            pps_d = 1'b1;
        end
        if (major_load && (timing_mode == MODE_FREERUN || timing_mode == MODE_EXT_PPS)) begin
            major_d = major_load_value;
        end
        if (ref_edge || ref_timer_q >= 32'(REF_TIMEOUT)) begin
            ref_timer_d = 32'h00000000;
        end else begin
            ref_timer_d = ref_timer_q + 32'h00000001;
        end
        case (sync_q)
            SYNC_FREE: begin
                if (timing_mode != MODE_FREERUN && timing_mode != MODE_RTC) begin
                    sync_d = SYNC_ACQUIRE;
                end
            end
            SYNC_ACQUIRE: begin
                // first edge jams the second boundary onto the reference
                if (ref_edge) begin
                    minor_d = 32'h00000000;
                    pps_d = 1'b1;
                    if (ref_gives_major) begin
                        major_d = ref_major;
                        tod_synced_d = 1'b1;
                    end
                    phase_d = 32'h00000000;
                    sync_d = SYNC_TRACK;
                end
            end
            SYNC_TRACK: begin
                if (ref_edge) begin
                    // proportional on phase plus frequency from phase change
                    phase_d = phase_now;
                    tune_d = tune_q - (32'($signed(phase_now) >>> TUNE_SHIFT) + freq_err);
                    locked_d = lock_allowed && phase_abs <= LOCK_WINDOW;
                    if (ref_gives_major) begin
                        tod_synced_d = 1'b1;
                    end
                end else if (ref_timer_q >= 32'(REF_TIMEOUT)) begin
                    sync_d = SYNC_HOLD;
                    locked_d = 1'b0;
                end
            end
            SYNC_HOLD: begin
                // tune word is kept so the oscillator coasts at its last setting
                if (ref_edge) begin
                    sync_d = SYNC_TRACK;
                    phase_d = phase_now;
                end
            end
            default: begin
                sync_d = SYNC_FREE;
            end
        endcase
        // a mode change to a generator drops any discipline
        if (timing_mode == MODE_FREERUN || timing_mode == MODE_RTC) begin
            sync_d = SYNC_FREE;
            locked_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            major_q <= 32'h00000000;
            minor_q <= 32'h00000000;
            pps_q <= 1'b0;
            sync_q <= SYNC_FREE;
            phase_q <= 32'h00000000;
            tune_q <= 32'h00000000;
            tod_synced_q <= 1'b0;
            locked_q <= 1'b0;
            hold_q <= 1'b0;
            track_q <= 1'b0;
            ref_timer_q <= 32'h00000000;
        end else begin
            major_q <= major_d;
            minor_q <= minor_d;
            pps_q <= pps_d;
            sync_q <= sync_d;
            phase_q <= phase_d;
            tune_q <= tune_d;
            tod_synced_q <= tod_synced_d;
            locked_q <= locked_d;
            hold_q <= sync_d == SYNC_HOLD;
            track_q <= sync_d == SYNC_TRACK && lock_allowed;
            ref_timer_q <= ref_timer_d;
        end
    end

    // all four sets take the same count in the same cycle
    tcr_capture_mem u_mem (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(cap_en),
        .wr_major(major_q),
        .wr_minor(minor_q),
        .rd_word(mem_word),
        .rd_data(mem_rdata)
    );

    always_comb begin
        status_word = 32'h00000000;
        status_word[ST_LOCKED] = locked_q;
        status_word[ST_TRACKING] = sync_q == SYNC_TRACK && lock_allowed;
        status_word[ST_HOLDOVER] = sync_q == SYNC_HOLD;
        status_word[ST_TOD_SYNCED] = tod_synced_q;
        status_word[ST_MODE_LSB +: 3] = timing_mode;
    end

    // host reads: memory stage then output stage, fixed two-cycle latency
    always_comb begin
        mem_word = 3'(host_addr - ADDR_WORD_BASE);
        rd_stage_d = host_access && !host_write;
        status_sel_d = host_addr == ADDR_STATUS;
        rdata_d = rdata_q;
        rvalid_d = rd_stage_q;
        if (rd_stage_q) begin
            // a request access in the same cycle is seen by a read one cycle later
            rdata_d = status_sel_q ? status_word : 32'h00000000;
        end
        if (rd_stage_q && word_sel_q) begin
            rdata_d = mem_rdata;
        end
    end

    // index decode for the word read stage
    always_comb begin
        word_sel_d = host_addr >= ADDR_WORD_BASE && host_addr <= ADDR_WORD_LAST;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h00000000;
            rd_stage_q <= 1'b0;
            rvalid_q <= 1'b0;
            status_sel_q <= 1'b0;
            word_sel_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rd_stage_q <= rd_stage_d;
            rvalid_q <= rvalid_d;
            status_sel_q <= status_sel_d;
            word_sel_q <= word_sel_d;
        end
    end

    // outputs straight from flops
    assign host_rdata = rdata_q;
    assign host_rvalid = rvalid_q;
    assign osc_tune = tune_q;
    assign local_pps = pps_q;
    assign ref_locked = locked_q;
    assign ref_tracking = track_q; // registered so the pin never glitches on decode
    assign holdover = hold_q;
endmodule

// ==== sim/tcr_time_capture_checker.sv ====
// checker for the time capture block: host answer timing and reference status
// assumes it is bound to tcr_time_capture and sees only its ports
`timescale 1ns/100ps
module tcr_time_capture_checker import tcr_pkg::*; #(
    parameter int REF_TIMEOUT = REF_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host access
    input wire logic host_access,
    input wire logic host_write,
    input wire logic [3:0] host_addr,
    input wire logic [31:0] host_rdata,
    input wire logic host_rvalid,
    // mode and status
    input wire logic [2:0] timing_mode,
    input wire logic [31:0] osc_tune,
    input wire logic local_pps,
    input wire logic ref_locked,
    input wire logic holdover
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // three cycles settle a mode change before status is judged
    sequence s_read;
        host_access && !host_write;
    endsequence
    sequence s_free3;
        (timing_mode == MODE_FREERUN) [*3];
    endsequence
    sequence s_rtc3;
        (timing_mode == MODE_RTC) [*3];
    endsequence
    property p_read_answer;
        s_read |-> ##2 host_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
    property p_answer_cause;
        host_rvalid |-> $past(host_access, 2) && !$past(host_write, 2);
    endproperty
    a_answer_cause: assert property (p_answer_cause) else $error("answer without read");
    property p_rdata_hold;
        !host_rvalid |-> $stable(host_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_unmapped_zero;
        (s_read ##0 (host_addr < ADDR_WORD_BASE || host_addr > ADDR_STATUS)) |-> ##2 host_rdata == 32'h0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("request index read");
    property p_pps_single;
        local_pps |=> !local_pps;
    endproperty
    a_pps_single: assert property (p_pps_single) else $error("second pulse too long");
    property p_free_idle;
        s_free3 |-> !ref_locked && !holdover;
    endproperty
    a_free_idle: assert property (p_free_idle) else $error("free run shows lock");
    property p_free_tune;
        s_free3 |-> $stable(osc_tune);
    endproperty
    a_free_tune: assert property (p_free_tune) else $error("free run steers");
    property p_rtc_idle;
        s_rtc3 |-> !ref_locked && !holdover;
    endproperty
    a_rtc_idle: assert property (p_rtc_idle) else $error("generator shows lock");
endmodule
bind tcr_time_capture tcr_time_capture_checker #(.REF_TIMEOUT(REF_TIMEOUT)) chk_u (.clk, .rst_n,
    .host_access, .host_write, .host_addr, .host_rdata, .host_rvalid, .timing_mode, .osc_tune,
    .local_pps, .ref_locked, .holdover);

// ==== sim/tcr_host_model.sv ====
// host side model: register strobes plus the mode and major time mailbox results
// assumes tasks are called one at a time, just after a rising edge
`timescale 1ns/100ps
module tcr_host_model import tcr_pkg::*; (
    // clock
    input wire logic clk,
    // host access
    output logic host_access,
    output logic host_write,
    output logic [3:0] host_addr,
    input wire logic [31:0] host_rdata,
    input wire logic host_rvalid,
    // mailbox results
    output logic [2:0] timing_mode,
    output logic major_load,
    output logic [31:0] major_load_value
);
    // idle bus at time zero
    initial begin
        host_access = 1'b0;
        host_write = 1'b0;
        host_addr = 4'h0;
        timing_mode = MODE_TIMECODE;
        major_load = 1'b0;
        major_load_value = 32'h0;
    end
    // strobe taken at next edge; an idle cycle follows so no strobe toggles twice
    task automatic access(input logic [3:0] a, input logic wr);
        host_addr = a;
        host_write = wr;
        host_access = 1'b1;
        @(posedge clk);
        #1;
        host_access = 1'b0;
        host_addr = ~a;
        @(posedge clk);
        #1;
    endtask
    // two requests on consecutive edges
    task automatic access2(input logic [3:0] a, input logic [3:0] b);
        host_write = 1'b0;
        host_addr = a;
        host_access = 1'b1;
        @(posedge clk);
        #1;
        host_addr = b;
        @(posedge clk);
        #1;
        host_access = 1'b0;
        host_addr = ~b;
    endtask
    // data taken as soon as the answer shows, bounded wait
    task automatic read(input logic [3:0] a, output logic [31:0] d);
        int n;
        d = 'x;
        n = 0;
        access(a, 1'b0);
        while (host_rvalid !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (host_rvalid === 1'b1) d = host_rdata;
    endtask
    // outcome of the mode select command
    task automatic set_mode(input logic [2:0] m);
        timing_mode = m;
        @(posedge clk);
        #1;
    endtask
    // outcome of the major time load command
    task automatic load_major(input logic [31:0] v);
        major_load_value = v;
        major_load = 1'b1;
        @(posedge clk);
        #1;
        major_load = 1'b0;
    endtask
endmodule

// ==== sim/tb_top.sv ====
// testbench for the time capture block: captures, mode status, reference sync
// assumes the host model drives the bus; reference timeout shortened to 200 cycles
`timescale 1ns/100ps
module tb_top import tcr_pkg::*;;
    localparam int RT = 200;
    logic clk, rst_n, host_access, host_write, host_rvalid, major_load, capture_edge_sense;
    logic first_capture_periodic, pin10_event_sel, pin14_event_sel, first_event_time_word_b_in, pin10_in;
    logic programmable_periodic_output, pin14_in, tcode_form_am, tcode_am_mark, sat_pps;
    logic sat_position_known, local_pps, ref_locked, ref_tracking, holdover;
    logic [3:0] host_addr, sat_count;
    logic [2:0] timing_mode;
    logic [31:0] host_rdata, major_load_value, tcode_am_major, tcode_ls_major, sat_major;
    logic [31:0] rtc_major, osc_tune, a0, b0, a1, b1, st;
    logic [2:0] modes [5] = '{MODE_TIMECODE, MODE_FREERUN, MODE_EXT_PPS, MODE_RTC, MODE_SATELLITE};
    int fails = 0;
    int total_checks = 0;
    tcr_time_capture #(.REF_TIMEOUT(RT)) dut_u (.clk, .rst_n, .host_access, .host_write,
        .host_addr, .host_rdata, .host_rvalid, .timing_mode, .major_load, .major_load_value,
        .capture_edge_sense, .first_capture_periodic, .pin10_event_sel, .pin14_event_sel,
        .first_event_time_word_b_in, .programmable_periodic_output, .pin10_in, .pin14_in, .tcode_form_am,
        .tcode_am_mark, .tcode_am_major, .tcode_ls_major, .sat_pps, .sat_major, .sat_count,
        .sat_position_known, .rtc_major, .osc_tune, .local_pps, .ref_locked, .ref_tracking,
        .holdover);
    tcr_host_model host_u (.clk, .host_access, .host_write, .host_addr, .host_rdata,
        .host_rvalid, .timing_mode, .major_load, .major_load_value);
    // 4 ns clock
    always #2 clk = ~clk;
    task automatic chk_word(input string w, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk_bit(input string w, input logic e, input logic g);
        chk_word(w, {31'h0, e}, {31'h0, g});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic read_pair(input logic [1:0] s, output logic [31:0] ma, output logic [31:0] mi);
        host_u.read(ADDR_WORD_BASE + {1'b0, s, 1'b0}, ma);
        host_u.read(ADDR_WORD_BASE + {1'b0, s, 1'b1}, mi);
    endtask
    task automatic grab;
        host_u.access(ADDR_DEMAND_REQ, 1'b0);
        read_pair(SET_DEMAND, a0, b0);
    endtask
    // pin edge and demand access on one edge must give the same time
    task automatic cap_same(input logic [1:0] s);
        grab();
        read_pair(s, a1, b1);
        chk_word("set major", a0, a1);
        chk_word("set minor", b0, b1);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // a hang shows as a failing verdict after 20000 cycles, so cut it short
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        results();
    end
    // main sequence
    initial begin
        {clk, rst_n, first_capture_periodic, first_event_time_word_b_in, programmable_periodic_output} = '0;
        {pin10_in, pin14_in, tcode_form_am, tcode_am_mark, sat_pps, sat_position_known} = '0;
        {capture_edge_sense, pin10_event_sel, pin14_event_sel} = 3'h7;
        {tcode_am_major, sat_major, sat_count} = '0;
        tcode_ls_major = 32'h0000_0055;
        rtc_major = 32'h0000_0033;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        host_u.set_mode(MODE_EXT_PPS);
        pin14_event_sel = 1'b0;
        repeat (3) begin
            pin14_in = 1'b1;
            tick(1);
            pin14_in = 1'b0;
            tick(40);
        end
        host_u.read(ADDR_STATUS, st);
        chk_bit("pps lock word", 1'b0, st[ST_LOCKED]);
        chk_bit("pps lock pin", 1'b0, ref_locked);
        chk_bit("pps tracking", 1'b0, ref_tracking);
        pin14_event_sel = 1'b1;
        host_u.set_mode(MODE_TIMECODE);
        host_u.access2(ADDR_DEMAND_REQ, ADDR_FIRST_REQ);
        tick(1);
        read_pair(SET_DEMAND, a0, b0);
        read_pair(SET_FIRST, a1, b1);
        chk_word("first major", a0, a1);
        chk_word("first minor", b0 + MINOR_STEP, b1);
        tick(10);
        read_pair(SET_DEMAND, a1, b1);
        chk_word("demand held", b0, b1);
        host_u.access(ADDR_DEMAND_REQ, 1'b1);
        read_pair(SET_DEMAND, a1, b1);
        chk_bit("demand moved", 1'b1, b1 != b0);
        host_u.read(4'hF, st);
        chk_word("unmapped", 32'h0, st);
        first_event_time_word_b_in = 1'b1;
        cap_same(SET_FIRST);
        programmable_periodic_output = 1'b1;
        tick(2);
        first_capture_periodic = 1'b1;
        capture_edge_sense = 1'b0;
        tick(2);
        programmable_periodic_output = 1'b0;
        cap_same(SET_FIRST);
        capture_edge_sense = 1'b1;
        pin10_in = 1'b1;
        cap_same(SET_SECOND);
        pin14_in = 1'b1;
        cap_same(SET_THIRD);
        read_pair(SET_SECOND, a0, b0);
        pin10_event_sel = 1'b0;
        pin10_in = 1'b0;
        tick(2);
        pin10_in = 1'b1;
        host_u.access2(ADDR_DEMAND_REQ, ADDR_FIRST_REQ);
        tick(1);
        read_pair(SET_SECOND, a1, b1);
        chk_word("second kept", b0, b1);
        foreach (modes[i]) begin
            host_u.set_mode(modes[i]);
            tick(3);
            host_u.read(ADDR_STATUS, st);
            chk_word("status mode", {29'h0, modes[i]}, {29'h0, st[ST_MODE_LSB +: 3]});
        end
        host_u.set_mode(MODE_FREERUN);
        tick(3);
        host_u.load_major(32'h0000_0123);
        grab();
        chk_word("loaded major", 32'h0000_0123, a0);
        host_u.set_mode(MODE_SATELLITE);
        sat_major = 32'h0000_0777;
        sat_count = 4'h3;
        for (int k = 0; k < 2; k++) begin
            sat_pps = 1'b1;
            tick(1);
            sat_pps = 1'b0;
            tick(2);
            grab();
            chk_word("sat major", k ? 32'h0000_0777 : 32'h0000_0123, a0);
            sat_count = 4'h1;
            sat_position_known = 1'b1;
        end
        chk_bit("sat minor jam", 1'b1, b0 < 32'h100);
        chk_bit("tracking", 1'b0, holdover);
        chk_bit("tracking pin", 1'b1, ref_tracking);
        tick(RT + 20);
        chk_bit("holdover", 1'b1, holdover);
        host_u.set_mode(MODE_FREERUN);
        host_u.set_mode(MODE_TIMECODE);
        tcode_form_am = 1'b1;
        tcode_am_major = 32'h0000_0ABC;
        tcode_am_mark = 1'b1;
        tick(1);
        tcode_am_mark = 1'b0;
        tick(2);
        grab();
        chk_word("code major", 32'h0000_0ABC, a0);
        results();
    end
endmodule
